// [mps_pkg.sv]
/*
 Package for the microprogram sequencer: widths, opcode encodings,
 register offsets and field positions for the AHB-Lite register window,
 and the packed structs that carry the sequencer pins.
 Assumes a single clock domain and a 32-bit AHB-Lite bus.
*/
// Behaviour
// - Decoder turns opcode and test flops into route, flag and stack controls.
// - Three-bit stack pointer with plus-one and minus-one neighbours.
// - Four ten-bit stack entries, read at pointer, written at pointer plus one.
// - Stack pointer loads on rising edge; master reset clears it.
// - Pointer takes plus one on call, minus one on return, else holds.
// - Stack writes only with write enable active; pointer top bit gates it.
// - Four saved return addresses block further stack writes.
// - Explicit-address flag low only for fetch and return, high otherwise.
// - Route outputs low except route branches one to three, per index.
// - Route branches and call take branch address and raise the flag.
// - Multiway: branch bits nine to three above the three multiway inputs.
// - Test-high branch jumps when selected test flop high, else counter plus one.
// - Test-low branch jumps when selected test flop low, else counter plus one.
// - Fetch takes counter plus one and drives both route outputs low.
// - Return takes the stack entry at the read pointer and decrements it.
// - Call writes counter plus one into the stack as return address.
// - Edge ending a call loads branch address and increments the pointer.
// - Pipeline mode passes next address through; otherwise outputs show counter.
// - Program counter loads the selected next address on every rising edge outside master reset.
// - Opcode map: 0 return, 1 call, 2 fetch, 3 multiway, prefixes select branches.
// - Pipeline select high means pipeline; master reset forces non-pipeline, clears counter.
// - Test inputs captured into test flops on rising edge of test strobe.
package mps_pkg;

    // Sequencer widths.
    localparam int MPS_ADDR_W = 10;
    localparam int MPS_SP_W = 3;
    localparam int MPS_STACK_DEPTH = 4;
    localparam int MPS_OP_W = 4;
    localparam int MPS_TEST_W = 4;
    localparam int MPS_MW_W = 3;

    // Opcode encodings and two-bit prefixes.
    localparam logic [3:0] MPS_OP_RET = 4'h0;
    localparam logic [3:0] MPS_OP_CALL = 4'h1;
    localparam logic [3:0] MPS_OP_FETCH = 4'h2;
    localparam logic [3:0] MPS_OP_MULTI = 4'h3;
    localparam logic [1:0] MPS_PFX_ROUTE = 2'h1;
    localparam logic [1:0] MPS_PFX_TEST_HI = 2'h3;
    localparam logic [1:0] MPS_PFX_TEST_LO = 2'h2;

    // Register window, byte offsets within the slave.
    localparam int MPS_DEC_W = 12;
    localparam logic [11:0] MPS_REG_CTRL = 12'h000;
    localparam logic [11:0] MPS_REG_STATUS = 12'h004;
    localparam logic [11:0] MPS_REG_TEST = 12'h008;
    localparam int MPS_CTRL_PIPE_BIT = 0;
    localparam logic MPS_CTRL_PIPE_RST = 1'b0;
    localparam int MPS_STATUS_SP_LSB = 16;
    localparam int MPS_STATUS_PIPE_BIT = 24;
    localparam int MPS_STATUS_FULL_BIT = 25;

    // Instruction class, one-hot.
    typedef enum logic [6:0] {
        MPS_C_RET = 7'h01,
        MPS_C_CALL = 7'h02,
        MPS_C_FETCH = 7'h04,
        MPS_C_MULTI = 7'h08,
        MPS_C_ROUTE = 7'h10,
        MPS_C_TEST_HI = 7'h20,
        MPS_C_TEST_LO = 7'h40
    } mps_op_class_t;

    // Sequencer pins into the block.
    typedef struct packed {
        logic [3:0] opcode_in;
        logic [9:0] branch_addr_in;
        logic [2:0] multiway_in;
        logic [3:0] test_in;
        logic test_strobe;
        logic master_reset_n;
    } mps_seq_in_t;

    // Sequencer pins out of the block.
    typedef struct packed {
        logic [9:0] next_addr_out;
        logic route_select_1;
        logic route_select_0;
        logic explicit_addr_flag;
    } mps_seq_out_t;

endpackage

// [mps_sequencer.sv]
/*
 Microprogram sequencer: program counter, four-level return stack,
 strobed test flops, instruction decoder and pipeline output selector,
 with an AHB-Lite slave for mode control and state readback.
 Assumes all pins are synchronous to hclk and a zero-wait bus master.
*/
`timescale 1ns/10ps
module mps_sequencer (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire mps_pkg::mps_seq_in_t seq_in,
    output mps_pkg::mps_seq_out_t seq_out
);
    import mps_pkg::*;

    // State.
    logic [MPS_ADDR_W-1:0] pc_q;
    logic [MPS_SP_W-1:0] sp_q;
    logic [MPS_ADDR_W-1:0] stk_q [MPS_STACK_DEPTH];
    logic [MPS_TEST_W-1:0] test_q;
    logic strobe_q;
    logic pipe_q;
    logic dph_wr_q;
    logic [MPS_DEC_W-1:0] dph_addr_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic hresp_q;

    // Pin fields.
    wire [MPS_OP_W-1:0] opcode = seq_in.opcode_in;
    wire [MPS_ADDR_W-1:0] branch = seq_in.branch_addr_in;
    wire mr_n = seq_in.master_reset_n;
    wire [1:0] op_pfx = opcode[3:2];
    wire [1:0] op_idx = opcode[1:0];

    // Instruction decode into one class; prefixes cover the branch groups.
    // The four full codes are tested before the prefixes, because codes 0 to 3
    // share the 00 prefix, which no branch group uses.
    mps_op_class_t op_class;
    assign op_class = (opcode == MPS_OP_RET) ? MPS_C_RET :
                      (opcode == MPS_OP_CALL) ? MPS_C_CALL :
                      (opcode == MPS_OP_FETCH) ? MPS_C_FETCH :
                      (opcode == MPS_OP_MULTI) ? MPS_C_MULTI :
                      (op_pfx == MPS_PFX_ROUTE) ? MPS_C_ROUTE :
                      (op_pfx == MPS_PFX_TEST_HI) ? MPS_C_TEST_HI :
                      MPS_C_TEST_LO;

    wire is_call = (op_class == MPS_C_CALL);
    wire is_ret = (op_class == MPS_C_RET);
    wire is_fetch = (op_class == MPS_C_FETCH);
    wire test_bit = test_q[op_idx];

    // Incrementers for the counter and the stack pointer; both wrap freely.
    wire [MPS_ADDR_W-1:0] pc_inc = pc_q + 10'h001;
    wire [MPS_SP_W-1:0] sp_inc = sp_q + 3'h1;
    wire [MPS_SP_W-1:0] sp_dec = sp_q - 3'h1;
    wire [1:0] rd_ptr = sp_q[1:0];
    wire [1:0] wr_ptr = sp_inc[1:0];

    // Input multiplexer choosing the next microinstruction address.
    logic [MPS_ADDR_W-1:0] next_addr;
    always_comb begin
        next_addr = pc_inc;
        case (op_class)
            MPS_C_RET: next_addr = stk_q[rd_ptr];
            MPS_C_CALL: next_addr = branch;
            MPS_C_ROUTE: next_addr = branch;
            MPS_C_MULTI: next_addr = {branch[9:3], seq_in.multiway_in};
            MPS_C_TEST_HI: next_addr = test_bit ? branch : pc_inc;
            MPS_C_TEST_LO: next_addr = test_bit ? pc_inc : branch;
            MPS_C_FETCH: next_addr = pc_inc;
            default: next_addr = pc_inc;
        endcase
    end

    // Next state of counter and pointer; master reset acts as a clocked clear.
    // Sampling it means that a glitch between edges cannot clear the counter.
    // The cost is one cycle before the address outputs read zero.
    wire [MPS_ADDR_W-1:0] pc_d = mr_n ? next_addr : '0;
    wire [MPS_SP_W-1:0] sp_d = !mr_n ? '0 :
                               is_call ? sp_inc :
                               is_ret ? sp_dec : sp_q;
    // The top pointer bit blocks pushes once four levels are held.
    // A call made at that depth still moves the pointer, so the matching
    // return pops past the lost entry; microcode must not nest deeper than four.
    wire push_en = is_call && mr_n && !sp_q[MPS_SP_W-1];
    wire strobe_rise = seq_in.test_strobe && !strobe_q;

    // Pipeline mode is only honoured outside master reset.
    wire pipe_mode = pipe_q && mr_n;
    wire stack_full = sp_q[MPS_SP_W-1];

    // Sequencer outputs; these follow the opcode without a register so that
    // pipeline mode keeps its same-cycle address, at the cost of a comb path.
    assign seq_out.next_addr_out = pipe_mode ? next_addr : pc_q;
    assign seq_out.explicit_addr_flag = !(is_ret || is_fetch);
    assign seq_out.route_select_0 = (op_class == MPS_C_ROUTE) && op_idx[0];
    assign seq_out.route_select_1 = (op_class == MPS_C_ROUTE) && op_idx[1];

    // Program counter and stack pointer registers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_q <= '0;
            sp_q <= '0;
        end else begin
            pc_q <= pc_d;
            sp_q <= sp_d;
        end
    end

    // Return stack; the write that the part performs while the clock is low
    // lands here at the closing edge, so a return in the next cycle sees it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < MPS_STACK_DEPTH; i++) begin
                stk_q[i] <= '0;
            end
        end else if (push_en) begin
            stk_q[wr_ptr] <= pc_inc;
        end
    end

    // Test flops capture on the strobe's rising edge, found by sampling.
    // A strobe pulse must therefore stand across at least one rising clock
    // edge, and the captured value steers a branch from the next cycle on.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strobe_q <= 1'b0;
            test_q <= '0;
        end else begin
            strobe_q <= seq_in.test_strobe;
            if (strobe_rise) begin
                test_q <= seq_in.test_in;
            end
        end
    end

    // AHB-Lite decode; only whole-word single transfers are expected.
    // Only the low twelve address bits are decoded, so the register window
    // repeats across whatever region the bus decoder gives this slave.
    wire ahb_take = hsel && htrans[1] && hready;
    wire [MPS_DEC_W-1:0] a_off = haddr[MPS_DEC_W-1:0];
    wire [31:0] rd_ctrl = {{(31-MPS_CTRL_PIPE_BIT){1'b0}}, pipe_q};
    wire [31:0] rd_status = {6'h00, stack_full, pipe_mode,
                             {(MPS_STATUS_PIPE_BIT-MPS_STATUS_SP_LSB-MPS_SP_W){1'b0}},
                             sp_q,
                             {(MPS_STATUS_SP_LSB-MPS_ADDR_W){1'b0}}, pc_q};
    wire [31:0] rd_test = {{(32-MPS_TEST_W){1'b0}}, test_q};
    wire [31:0] rd_mux = (a_off == MPS_REG_CTRL) ? rd_ctrl :
                         (a_off == MPS_REG_STATUS) ? rd_status :
                         (a_off == MPS_REG_TEST) ? rd_test : 32'h0000_0000;
    wire ctrl_wr = dph_wr_q && (dph_addr_q == MPS_REG_CTRL);

    // Address phase capture and read data, registered so the data phase
    // always completes with no wait state.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wr_q <= 1'b0;
            dph_addr_q <= '0;
            hrdata_q <= 32'h0000_0000;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end else begin
            dph_wr_q <= ahb_take && hwrite;
            dph_addr_q <= ahb_take ? a_off : dph_addr_q;
            hrdata_q <= (ahb_take && !hwrite) ? rd_mux : 32'h0000_0000;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end
    end

    // Control register: software picks pipeline or non-pipeline mode.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pipe_q <= MPS_CTRL_PIPE_RST;
        end else if (ctrl_wr) begin
            pipe_q <= hwdata[MPS_CTRL_PIPE_BIT];
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;

    // Checks on the sequencer behaviour.
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_flag_misc_low: assert property (
        seq_out.explicit_addr_flag == !(opcode == MPS_OP_RET || opcode == MPS_OP_FETCH))
        else $error("explicit address flag wrong for the opcode");
    a_route_pattern: assert property (
        {seq_out.route_select_1, seq_out.route_select_0} ==
        ((op_class == MPS_C_ROUTE) ? op_idx : 2'b00))
        else $error("route select outputs wrong for opcode");
    a_call_loads_pc: assert property ((is_call && mr_n) |=> (pc_q == $past(branch)
        && sp_q == $past(sp_inc)))
        else $error("call did not load branch address and bump pointer");
    a_ret_pops_sp: assert property ((is_ret && mr_n) |=> (sp_q == $past(sp_dec)
        && pc_q == $past(stk_q[rd_ptr])))
        else $error("return did not pop the stack");
    a_push_saves_ret: assert property ((push_en) |=> stk_q[$past(wr_ptr)] == $past(pc_inc))
        else $error("call did not save counter plus one");
    a_full_blocks_push: assert property ((is_call && stack_full) |=>
        (stk_q[0] == $past(stk_q[0]) && stk_q[1] == $past(stk_q[1])
        && stk_q[2] == $past(stk_q[2]) && stk_q[3] == $past(stk_q[3])))
        else $error("stack written while four levels held");
    a_fetch_step: assert property ((is_fetch && mr_n) |=>
        pc_q == $past(pc_q) + 10'h001)
        else $error("fetch did not advance the counter by one");
    a_multiway_low: assert property ((op_class == MPS_C_MULTI) |->
        next_addr == {branch[9:3], seq_in.multiway_in})
        else $error("multiway address not formed from branch and multiway inputs");
    a_test_hi_take: assert property ((op_class == MPS_C_TEST_HI) |->
        next_addr == (test_q[op_idx] ? branch : pc_inc))
        else $error("test-high branch chose wrong source");
    a_test_lo_take: assert property ((op_class == MPS_C_TEST_LO) |->
        next_addr == (test_q[op_idx] ? pc_inc : branch))
        else $error("test-low branch chose wrong source");
    a_output_mode: assert property (seq_out.next_addr_out == (pipe_mode ? next_addr : pc_q))
        else $error("address output does not follow mode");
    a_master_clear: assert property (!mr_n |=> (pc_q == '0 && sp_q == '0
        && (mr_n || seq_out.next_addr_out == '0)))
        else $error("master reset did not clear counter and pointer");
    a_test_capture: assert property (strobe_rise |=> test_q == $past(seq_in.test_in))
        else $error("test flops missed the strobe edge");
    a_pc_follows: assert property (mr_n |=> pc_q == $past(next_addr))
        else $error("counter did not load the next address");

    // The pointer pop step is checked against the pointer itself rather than the
    // shared decrementer, so a fault in sp_dec shows up here.
    a_ptr_pop_step: assert property (
        (is_ret && mr_n) |=>
        sp_q == $past(sp_q) - 3'h1)
        else $error("return did not step the pointer down by one");

    a_ptr_hold: assert property (
        (mr_n && !is_call && !is_ret) |=>
        sp_q == $past(sp_q))
        else $error("stack pointer moved on a plain instruction");

    // The saved return address is worked out from the counter itself, so a
    // broken incrementer cannot hide behind its own output.
    a_ret_addr_value: assert property (
        push_en |=>
        stk_q[$past(wr_ptr)] == $past(pc_q) + 10'h001)
        else $error("saved return address is not counter plus one");

    // Only an enabled push may alter the stack; everything else leaves it.
    a_stack_quiet: assert property (
        !push_en |=>
        (stk_q[0] == $past(stk_q[0]) && stk_q[1] == $past(stk_q[1])
        && stk_q[2] == $past(stk_q[2]) && stk_q[3] == $past(stk_q[3])))
        else $error("stack entry changed without a push");

    // Decoder checks written from the opcode bits, not from the class signal.
    a_route_target: assert property (
        (op_pfx == MPS_PFX_ROUTE && mr_n) |=>
        pc_q == $past(branch))
        else $error("route branch did not load the branch address");

    a_route_flag_high: assert property (
        (op_pfx == MPS_PFX_ROUTE || opcode == MPS_OP_CALL) |->
        seq_out.explicit_addr_flag)
        else $error("explicit address flag low on a route branch or call");

    a_quiet_routes: assert property (
        (opcode == MPS_OP_FETCH || opcode == MPS_OP_RET || opcode == MPS_OP_CALL) |->
        !(seq_out.route_select_0 || seq_out.route_select_1))
        else $error("route output high on fetch, call or return");

    a_multi_target: assert property (
        (opcode == MPS_OP_MULTI && mr_n) |=>
        (pc_q[2:0] == $past(seq_in.multiway_in) && (pc_q >> 3) == ($past(branch) >> 3)))
        else $error("multiway branch loaded the wrong address");

    // Master reset must close the pipeline path even with the mode bit set.
    a_mr_nonpipe: assert property (
        !mr_n |-> seq_out.next_addr_out == pc_q)
        else $error("pipeline path open during master reset");

    a_test_hold: assert property (
        !strobe_rise |=> test_q == $past(test_q))
        else $error("test flops changed without a strobe edge");

    // Bus checks: the slave never stalls and never reports an error, and read
    // data stands only in the data phase of a read, so stale data cannot leak.
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("slave stalled or answered with an error");

    a_rdata_idle: assert property (
        !(ahb_take && !hwrite) |=> hrdata == 32'h0000_0000)
        else $error("read data left on the bus outside a read");

    a_status_read: assert property (
        (ahb_take && !hwrite && a_off == MPS_REG_STATUS) |=>
        (hrdata[9:0] == $past(pc_q) && hrdata[18:16] == $past(sp_q)))
        else $error("status read did not show counter and pointer");

    a_test_read: assert property (
        (ahb_take && !hwrite && a_off == MPS_REG_TEST) |=>
        hrdata == {28'h000_0000, $past(test_q)})
        else $error("test read did not show the test flops");

    a_ctrl_takes: assert property (
        ctrl_wr |=> pipe_q == $past(hwdata[MPS_CTRL_PIPE_BIT]))
        else $error("control write did not set the pipeline bit");

    c_nested_calls: cover property ((is_call && mr_n)[*4] ##1 (is_call && stack_full));
    c_call_return: cover property ((is_call && mr_n) ##1 (is_ret && mr_n));
    c_pipe_branch: cover property (pipe_mode && op_class == MPS_C_TEST_HI && test_bit);
    c_ahb_ctrl_write: cover property (ctrl_wr && hwdata[MPS_CTRL_PIPE_BIT]);
    c_pipe_return: cover property (pipe_mode && is_ret);
endmodule

// [mps_ctl_mem.sv]
/*
 Control memory and microinstruction register that stand beside the sequencer.
 Assumes the bench loads the memory words and sets the pipeline flag to match the sequencer mode.
*/
`timescale 1ns/10ps
module mps_ctl_mem (
    input wire logic hclk,
    input wire logic pipe,
    input wire logic [9:0] addr,
    output logic [3:0] opcode,
    output logic [9:0] branch,
    output logic [2:0] multiway
);
    // Each word is opcode, branch address and multiway bits.
    logic [16:0] mem [0:1023];
    logic [16:0] word_q;
    logic [16:0] word;

    // The microinstruction register captures the word at the address shown on each edge.
    always_ff @(posedge hclk) begin
        word_q <= mem[addr];
    end

    // Pipeline mode must be buffered, or the instruction would change under the sequencer.
    assign word = pipe ? word_q : mem[addr];
    assign {opcode, branch, multiway} = word;
endmodule

// [mps_sequencer_bench.sv]
/*
 Self-checking bench for the sequencer: runs a microprogram from the control memory model
 and reaches the mode and status registers over AHB-Lite.
 Assumes the sequencer is the only slave, so hreadyout is fed back as hready.
*/
`timescale 1ns/10ps
module mps_sequencer_bench;
    import mps_pkg::*;
    logic hclk, hresetn, hsel, hwrite, pipe, strobe, mr_n;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, mw;
    logic [3:0] op, test_in;
    logic [9:0] ba;
    logic hreadyout, hresp;
    mps_seq_in_t seq_in;
    mps_seq_out_t seq_out;
    logic [9:0] row_a [0:31];
    logic [2:0] row_e [0:31];
    int nrows = 0, failures = 0, compares = 0, cycles = 0;

    // Sequencer pins gathered into the carrier struct.
    assign seq_in = {op, ba, mw, test_in, strobe, mr_n};

    mps_sequencer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .seq_in(seq_in),
        .seq_out(seq_out));
    mps_ctl_mem cmem (.hclk(hclk), .pipe(pipe), .addr(seq_out.next_addr_out), .opcode(op),
        .branch(ba), .multiway(mw));

    // Free-running clock at the bus rate.
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    task automatic end_of_test();
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // A hang would otherwise stall the run, so the cycle count is capped.
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One single word transfer; entered just after a rising edge.
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        chk("hresp", 32'h0, 32'(hresp));
    endtask

    task automatic prog(input logic [9:0] a, input logic [3:0] o, input logic [9:0] b,
            input logic [2:0] m, input logic [2:0] e);
        cmem.mem[a] = {o, b, m};
        row_a[nrows] = a;
        row_e[nrows] = e;
        nrows++;
    endtask

    initial begin
        {hresetn, hsel, hwrite, pipe, strobe, mr_n} = '0;
        {haddr, hwdata, htrans, hsize, test_in} = '0;
        // Five nested calls, four returns, fetch, all routes, multiway and every test branch.
        prog(10'h000, 4'h1, 10'h100, 3'h0, 3'b001);
        prog(10'h100, 4'h1, 10'h200, 3'h0, 3'b001);
        prog(10'h200, 4'h1, 10'h300, 3'h0, 3'b001);
        prog(10'h300, 4'h1, 10'h310, 3'h0, 3'b001);
        prog(10'h310, 4'h1, 10'h320, 3'h0, 3'b001);
        prog(10'h320, 4'h0, 10'h3aa, 3'h0, 3'b000);
        prog(10'h001, 4'h0, 10'h3aa, 3'h0, 3'b000);
        prog(10'h301, 4'h0, 10'h3aa, 3'h0, 3'b000);
        prog(10'h201, 4'h0, 10'h3aa, 3'h0, 3'b000);
        prog(10'h101, 4'h2, 10'h3aa, 3'h0, 3'b000);
        prog(10'h102, 4'h5, 10'h140, 3'h0, 3'b011);
        prog(10'h140, 4'h6, 10'h150, 3'h0, 3'b101);
        prog(10'h150, 4'h7, 10'h160, 3'h0, 3'b111);
        prog(10'h160, 4'h4, 10'h170, 3'h0, 3'b001);
        prog(10'h170, 4'h3, 10'h3ff, 3'h5, 3'b001);
        prog(10'h3fd, 4'hc, 10'h010, 3'h0, 3'b001);
        prog(10'h010, 4'hd, 10'h020, 3'h0, 3'b001);
        prog(10'h011, 4'h9, 10'h030, 3'h0, 3'b001);
        prog(10'h030, 4'ha, 10'h040, 3'h0, 3'b001);
        prog(10'h031, 4'hf, 10'h033, 3'h0, 3'b001);
        prog(10'h032, 4'hb, 10'h050, 3'h0, 3'b001);
        prog(10'h050, 4'he, 10'h060, 3'h0, 3'b001);
        prog(10'h060, 4'h8, 10'h070, 3'h0, 3'b001);
        prog(10'h061, 4'h2, 10'h3aa, 3'h0, 3'b000);
        prog(10'h062, 4'h4, 10'h062, 3'h0, 3'b001);
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        test_in <= 4'h5;
        @(posedge hclk);
        strobe <= 1'b1;
        @(posedge hclk);
        test_in <= 4'ha;
        @(negedge hclk);
        chk("next_addr_out", 32'h0, 32'(seq_out.next_addr_out));
        @(posedge hclk);
        mr_n <= 1'b1;
        // Each row's address is the next address chosen by the row before it.
        for (int i = 0; i < nrows; i++) begin
            @(negedge hclk);
            chk("next_addr_out", 32'(row_a[i]), 32'(seq_out.next_addr_out));
            chk("route_flag", 32'(row_e[i]), 32'(seq_out[2:0]));
        end
        @(posedge hclk);
        ahb(1'b0, 32'h004, 32'h0);
        chk("status", 32'h0001_0062, rd);
        ahb(1'b0, 32'h008, 32'h0);
        chk("test_flops", 32'h5, rd);
        ahb(1'b0, 32'h00c, 32'h0);
        chk("unmapped", 32'h0, rd);
        ahb(1'b1, 32'h000, 32'h1);
        pipe <= 1'b1;
        ahb(1'b0, 32'h000, 32'h0);
        chk("ctrl", 32'h1, rd);
        mr_n <= 1'b0;
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        chk("next_addr_out", 32'h0, 32'(seq_out.next_addr_out));
        @(posedge hclk);
        mr_n <= 1'b1;
        // In pipeline mode the output already shows the address that the row chooses.
        for (int i = 1; i < nrows; i++) begin
            @(negedge hclk);
            chk("next_addr_out", 32'(row_a[i]), 32'(seq_out.next_addr_out));
            chk("route_flag", 32'(row_e[i-1]), 32'(seq_out[2:0]));
        end
        end_of_test();
    end
endmodule
